// ===== inc/strap_config_defs.vh
// Functional notes
// - lane width strap low: one four-lane port
// - strap changes after window are ignored
// - even strap high powers both ports down
// - even power-down covers all four lanes
// - odd strap high powers odd port down
// - four-lane mode keeps odd port powered down
// - software override replaces even strap value
// - software override replaces odd strap value
// - strap drivers enabled only in test mode
`ifndef STRAP_CONFIG_DEFS_VH
`define STRAP_CONFIG_DEFS_VH

// sampling window after hard reset release, in core clocks
`define STRAP_HOLD_CYCLES     10
`define STRAP_CNT_W           4
// reset values of captured straps (pull resistor defaults)
`define LANE_WIDTH_RST        1'b0
`define PWRDN_RST             1'b1
// reset values of software fields, pin drivers and read data
`define SW_FIELD_RST          1'b0
`define OE_N_OFF              1'b1
`define DRV_RST               1'b0
`define RDATA_IDLE            32'h0000_0000
// strap slots in the synchronised vector, and lanes per macro
`define PIN_COUNT             3
`define PIN_LANE              0
`define PIN_EVEN              1
`define PIN_ODD               2
`define LANE_COUNT            4
// register map, word offsets
`define ADDR_W                4
`define REG_STATUS            4'h0
`define REG_OVERRIDE          4'h1
`define REG_TEST              4'h2
// status bit positions
`define ST_LANE_WIDTH         0
`define ST_EVEN_STRAP         1
`define ST_ODD_STRAP          2
`define ST_EVEN_PD            3
`define ST_ODD_PD             4
`define ST_DONE               5
// override bit positions
`define OV_EVEN_EN            0
`define OV_EVEN_VAL           1
`define OV_ODD_EN             2
`define OV_ODD_VAL            3
// test bit positions
`define TS_MODE               0
`define TS_DRIVE              1

`endif

// ===== logic/strap_sync.v
// three-stage synchroniser with agreement of the last two stages
module strap_sync #(
	parameter WIDTH = 3
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// async pins in, settled levels out
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] level_q
);
	reg [WIDTH-1:0] s1_q;
	reg [WIDTH-1:0] s2_q;
	reg [WIDTH-1:0] s3_q;
	genvar i;

	////////////////////////////////////////////////////////////////
	// per-bit chain; a level counts once stages two and three agree
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (rst) begin
					s1_q[i]    <= 1'b0;
					s2_q[i]    <= 1'b0;
					s3_q[i]    <= 1'b0;
					level_q[i] <= 1'b0;
				end else begin
					s1_q[i] <= pin_in[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						level_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate
endmodule

// ===== logic/serial_port_strap_config.v
// Implementation choices: the address map and the strobed register port.
`include "strap_config_defs.vh"

// strap capture and power-down control for an even/odd serial port pair
module serial_port_strap_config #(
	parameter HOLD_CYCLES = `STRAP_HOLD_CYCLES
) (
	// clock and synchronous reset
	input  wire                clk,
	input  wire                rst,
	// strap pins, each split into in/out/enable (enable low drives)
	input  wire                lane_width_strap_i,
	output reg                 lane_width_strap_o,
	output reg                 lane_width_strap_oe_n,
	input  wire                even_port_powerdown_strap_i,
	output reg                 even_port_powerdown_strap_o,
	output reg                 even_port_powerdown_strap_oe_n,
	input  wire                odd_port_powerdown_strap_i,
	output reg                 odd_port_powerdown_strap_o,
	output reg                 odd_port_powerdown_strap_oe_n,
	// register port
	input  wire [`ADDR_W-1:0]  addr,
	input  wire [31:0]         wdata,
	input  wire                wr,
	input  wire                rd,
	output reg  [31:0]         rdata,
	// controls to the port pair
	output reg                 single_lane_mode,
	output reg                 even_port_pd,
	output reg                 odd_port_pd,
	output reg  [3:0]          lane_pd
);
	// window state
	wire [`PIN_COUNT-1:0]   pin_level;
	reg  [`STRAP_CNT_W-1:0] win_cnt_q;
	reg  [`STRAP_CNT_W-1:0] win_cnt_d;
	reg                     done_q;
	reg                     done_d;

	// captured straps
	reg                     lane_width_q;
	reg                     even_strap_q;
	reg                     odd_strap_q;

	// software fields
	reg                     even_ov_en_q;
	reg                     even_ov_val_q;
	reg                     odd_ov_en_q;
	reg                     odd_ov_val_q;
	reg                     test_mode_q;
	reg                     test_drive_q;

	// decode results and register images
	reg                     even_pd_d;
	reg                     odd_pd_d;
	reg  [31:0]             status_word;
	reg  [31:0]             override_word;
	reg  [31:0]             test_word;
	reg  [31:0]             rdata_d;
	genvar                  ln;

	// every lane of the shared serializer macro switches together
	localparam LANES = `LANE_COUNT;

	////////////////////////////////////////////////////////////////
	// an enabled software override stands in for the captured strap;
	// the same choice serves both ports
	function pick_level;
		input ov_en;
		input ov_val;
		input strap_level;
		begin
			pick_level = ov_en ? ov_val : strap_level;
		end
	endfunction

	// register select, shared by both write processes
	function addr_hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] reg_addr;
		begin
			addr_hit = (a == reg_addr);
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// pins cross into the core clock before anything looks at them
	strap_sync #(
		.WIDTH (`PIN_COUNT)
	) u_sync (
		.clk     (clk),
		.rst     (rst),
		.pin_in  ({odd_port_powerdown_strap_i, even_port_powerdown_strap_i,
		           lane_width_strap_i}),
		.level_q (pin_level)
	);

	////////////////////////////////////////////////////////////////
	// window counter; it stops once the window closes instead of
	// wrapping, so the capture can never reopen before the next reset
	always @* begin
		win_cnt_d = win_cnt_q;
		done_d    = done_q;
		if (!done_q) begin
			win_cnt_d = win_cnt_q + 1'b1;
			if (win_cnt_q == HOLD_CYCLES[`STRAP_CNT_W-1:0] - 1'b1) begin
				done_d = 1'b1;
			end
		end
	end

	// counter and window flag registers
	always @(posedge clk) begin
		if (rst) begin
			win_cnt_q <= {`STRAP_CNT_W{1'b0}};
			done_q    <= 1'b0;
		end else begin
			win_cnt_q <= win_cnt_d;
			done_q    <= done_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// sampling window: follow the pins while the board holds them,
	// then freeze; sync latency is covered because the board keeps
	// the level stable through the whole window
	always @(posedge clk) begin
		if (rst) begin
			lane_width_q <= `LANE_WIDTH_RST;
			even_strap_q <= `PWRDN_RST;
			odd_strap_q  <= `PWRDN_RST;
		end else if (!done_q) begin
			lane_width_q <= pin_level[`PIN_LANE];
			even_strap_q <= pin_level[`PIN_EVEN];
			odd_strap_q  <= pin_level[`PIN_ODD];
		end
		// after the window the pins are never looked at again
	end

	////////////////////////////////////////////////////////////////
	// software writes to the override register; the fields only
	// reach the outputs once the window has closed
	always @(posedge clk) begin
		if (rst) begin
			even_ov_en_q  <= `SW_FIELD_RST;
			even_ov_val_q <= `SW_FIELD_RST;
			odd_ov_en_q   <= `SW_FIELD_RST;
			odd_ov_val_q  <= `SW_FIELD_RST;
		end else if (wr && addr_hit(addr, `REG_OVERRIDE)) begin
			even_ov_en_q  <= wdata[`OV_EVEN_EN];
			even_ov_val_q <= wdata[`OV_EVEN_VAL];
			odd_ov_en_q   <= wdata[`OV_ODD_EN];
			odd_ov_val_q  <= wdata[`OV_ODD_VAL];
		end
	end

	// software writes to the test register; the drive bit reaches
	// the pins only while the mode bit is set
	always @(posedge clk) begin
		if (rst) begin
			test_mode_q  <= `SW_FIELD_RST;
			test_drive_q <= `SW_FIELD_RST;
		end else if (wr && addr_hit(addr, `REG_TEST)) begin
			test_mode_q  <= wdata[`TS_MODE];
			test_drive_q <= wdata[`TS_DRIVE];
		end
	end

	////////////////////////////////////////////////////////////////
	// power-down decode from captured straps and overrides
	always @* begin
		even_pd_d = pick_level(even_ov_en_q, even_ov_val_q, even_strap_q);
		odd_pd_d  = pick_level(odd_ov_en_q, odd_ov_val_q, odd_strap_q);
		if (even_pd_d) begin
			odd_pd_d = 1'b1;
		end
		// four-lane mode beats software: the odd port has no lanes left
		if (!lane_width_q) begin
			odd_pd_d = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// mode output; reads four-lane until the window closes, so the
	// port pair never starts up in a half-decided configuration
	always @(posedge clk) begin
		if (rst) begin
			single_lane_mode <= `LANE_WIDTH_RST;
		end else if (done_q) begin
			single_lane_mode <= lane_width_q;
		end
	end

	// port power-down; both ports stay down until the window closes
	always @(posedge clk) begin
		if (rst) begin
			even_port_pd <= `PWRDN_RST;
			odd_port_pd  <= `PWRDN_RST;
		end else if (done_q) begin
			even_port_pd <= even_pd_d;
			odd_port_pd  <= odd_pd_d;
		end
	end

	// one flop per lane, all fed by the even-port decision; no lane
	// of the macro can be powered on its own
	generate
		for (ln = 0; ln < LANES; ln = ln + 1) begin : g_lane
			always @(posedge clk) begin
				if (rst) begin
					lane_pd[ln] <= `PWRDN_RST;
				end else if (done_q) begin
					lane_pd[ln] <= even_pd_d;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// pin drivers: only test mode may enable them, so in normal
	// operation the board straps never see contention
	always @(posedge clk) begin
		if (rst) begin
			lane_width_strap_oe_n <= `OE_N_OFF;
			lane_width_strap_o    <= `DRV_RST;
		end else begin
			lane_width_strap_oe_n <= ~test_mode_q;
			lane_width_strap_o    <= test_drive_q;
		end
	end

	// even power-down pin driver
	always @(posedge clk) begin
		if (rst) begin
			even_port_powerdown_strap_oe_n <= `OE_N_OFF;
			even_port_powerdown_strap_o    <= `DRV_RST;
		end else begin
			even_port_powerdown_strap_oe_n <= ~test_mode_q;
			even_port_powerdown_strap_o    <= test_drive_q;
		end
	end

	// odd power-down pin driver
	always @(posedge clk) begin
		if (rst) begin
			odd_port_powerdown_strap_oe_n <= `OE_N_OFF;
			odd_port_powerdown_strap_o    <= `DRV_RST;
		end else begin
			odd_port_powerdown_strap_oe_n <= ~test_mode_q;
			odd_port_powerdown_strap_o    <= test_drive_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// register images, assembled apart from the read mux
	always @* begin
		status_word                 = `RDATA_IDLE;
		status_word[`ST_LANE_WIDTH] = lane_width_q;
		status_word[`ST_EVEN_STRAP] = even_strap_q;
		status_word[`ST_ODD_STRAP]  = odd_strap_q;
		status_word[`ST_EVEN_PD]    = even_port_pd;
		status_word[`ST_ODD_PD]     = odd_port_pd;
		status_word[`ST_DONE]       = done_q;
	end

	always @* begin
		override_word               = `RDATA_IDLE;
		override_word[`OV_EVEN_EN]  = even_ov_en_q;
		override_word[`OV_EVEN_VAL] = even_ov_val_q;
		override_word[`OV_ODD_EN]   = odd_ov_en_q;
		override_word[`OV_ODD_VAL]  = odd_ov_val_q;
	end

	always @* begin
		test_word            = `RDATA_IDLE;
		test_word[`TS_MODE]  = test_mode_q;
		test_word[`TS_DRIVE] = test_drive_q;
	end

	// read mux; unmapped addresses read zero, so software can probe
	// the map without side effects
	always @* begin
		case (addr)
			`REG_STATUS:   rdata_d = status_word;
			`REG_OVERRIDE: rdata_d = override_word;
			`REG_TEST:     rdata_d = test_word;
			default:       rdata_d = `RDATA_IDLE;
		endcase
	end

	// read data valid only the cycle after the strobe; dropping back
	// to zero keeps a stale word from passing as a fresh answer
	always @(posedge clk) begin
		if (rst) begin
			rdata <= `RDATA_IDLE;
		end else if (rd) begin
			rdata <= rdata_d;
		end else begin
			rdata <= `RDATA_IDLE;
		end
	end
endmodule

// ===== testbench/serial_port_strap_config_sva.sv
`include "strap_config_defs.vh"

// port-level checks on the strap loader
module serial_port_strap_config_sva #(
	parameter int HOLD_CYCLES = 10
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// watched ports
	input wire logic        lane_width_strap_oe_n,
	input wire logic        even_port_powerdown_strap_oe_n,
	input wire logic        odd_port_powerdown_strap_oe_n,
	input wire logic [3:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        single_lane_mode,
	input wire logic        even_port_pd,
	input wire logic        odd_port_pd,
	input wire logic [3:0]  lane_pd
);
	// margin covers the synchroniser delay past the window
	localparam int SETTLE = HOLD_CYCLES + 8;
	logic [7:0] cnt_q;
	wire        oe_off = lane_width_strap_oe_n & even_port_powerdown_strap_oe_n
		& odd_port_powerdown_strap_oe_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	// cycles since reset release, saturating
	always_ff @(posedge clk) begin
		if (rst)
			cnt_q <= 8'h00;
		else if (cnt_q != 8'hFF)
			cnt_q <= cnt_q + 8'h01;
	end
	property p_lanes; lane_pd == {4{even_port_pd}}; endproperty
	a_lanes: assert property (p_lanes) else $error("lane power-down split");
	property p_four_lane; !single_lane_mode |-> odd_port_pd; endproperty
	a_four_lane: assert property (p_four_lane) else $error("odd port up in wide mode");
	property p_even_both; even_port_pd |-> odd_port_pd; endproperty
	a_even_both: assert property (p_even_both) else $error("odd up with even down");
	property p_test_off;
		wr && addr == `REG_TEST && !wdata[`TS_MODE] |-> ##[1:2] oe_off;
	endproperty
	a_test_off: assert property (p_test_off) else $error("drivers on outside test");
	property p_rd_idle; (!$past(rd) || $past(addr) > `REG_TEST) |-> rdata == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
	property p_frozen; cnt_q > SETTLE |-> $stable(single_lane_mode); endproperty
	a_frozen: assert property (p_frozen) else $error("mode moved after window");
	property p_odd_ov;
		wr && addr == `REG_OVERRIDE && wdata[`OV_ODD_EN] && wdata[`OV_ODD_VAL] |-> ##2 odd_port_pd;
	endproperty
	a_odd_ov: assert property (p_odd_ov) else $error("odd override ignored");
	property p_even_ov;
		wr && addr == `REG_OVERRIDE && wdata[`OV_EVEN_EN] && wdata[`OV_EVEN_VAL]
		|-> ##2 even_port_pd && odd_port_pd;
	endproperty
	a_even_ov: assert property (p_even_ov) else $error("even override ignored");
	property p_rst_vals; cnt_q == 8'h00 |-> oe_off && even_port_pd && !single_lane_mode; endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bad state after reset");
	c_ov: cover property (wr && addr == `REG_OVERRIDE);
	c_test: cover property (!lane_width_strap_oe_n);
	c_single: cover property (single_lane_mode && !odd_port_pd);
endmodule

bind serial_port_strap_config serial_port_strap_config_sva #(.HOLD_CYCLES(HOLD_CYCLES)) chk (
	.clk                            (clk),
	.rst                            (rst),
	.lane_width_strap_oe_n          (lane_width_strap_oe_n),
	.even_port_powerdown_strap_oe_n (even_port_powerdown_strap_oe_n),
	.odd_port_powerdown_strap_oe_n  (odd_port_powerdown_strap_oe_n),
	.addr                           (addr),
	.wdata                          (wdata),
	.wr                             (wr),
	.rd                             (rd),
	.rdata                          (rdata),
	.single_lane_mode               (single_lane_mode),
	.even_port_pd                   (even_port_pd),
	.odd_port_pd                    (odd_port_pd),
	.lane_pd                        (lane_pd)
);

// ===== testbench/strap_board.sv
// board strap resistors with the device's test drive on top
module strap_board (
	// resistor levels
	input  wire logic [2:0] tie,
	// device drive, enable low drives
	input  wire logic [2:0] drv,
	input  wire logic [2:0] drv_oe_n,
	// resolved pin levels
	output wire logic [2:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// resistor wins unless the device drives
	assign pin = (drv & ~drv_oe_n) | (tie & drv_oe_n);
endmodule

// ===== testbench/serial_port_strap_config_bench.sv
`include "strap_config_defs.vh"

module serial_port_strap_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [2:0] tie = 3'h0;
	logic [2:0] so, soe_n, pin;
	logic [31:0] rdata;
	logic slm, epd, opd, lw, ep, op, odd;
	logic [3:0] lane_pd;
	int fail_count = 0, n_compared = 0, cyc = 0;
	serial_port_strap_config uut (.clk(clk), .rst(rst), .lane_width_strap_i(pin[0]),
		.lane_width_strap_o(so[0]), .lane_width_strap_oe_n(soe_n[0]),
		.even_port_powerdown_strap_i(pin[1]), .even_port_powerdown_strap_o(so[1]),
		.even_port_powerdown_strap_oe_n(soe_n[1]), .odd_port_powerdown_strap_i(pin[2]),
		.odd_port_powerdown_strap_o(so[2]), .odd_port_powerdown_strap_oe_n(soe_n[2]),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .single_lane_mode(slm),
		.even_port_pd(epd), .odd_port_pd(opd), .lane_pd(lane_pd));
	strap_board board (.tie(tie), .drv(so), .drv_oe_n(soe_n), .pin(pin));
	////////////////////////////////////////
	// 25 MHz clock
	initial forever #20 clk = ~clk;
	// hang guard, runs need far fewer cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_compared++;
		if (seen !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, seen);
		end
	endtask
	task automatic close_out();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// straps settle from reset assertion through the window
	task automatic restart(input logic [2:0] t);
		@(posedge clk);
		tie <= t;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (24) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check("rdata", rdata, e);
	endtask
	// every strap combination, then overrides and test drive
	initial begin
		for (int i = 0; i < 8; i++) begin
			{op, ep, lw} = 3'(i);
			odd = ep | op | !lw;
			restart(3'(i));
			tie <= ~3'(i);
			repeat (4) @(posedge clk);
			#1;
			check("outs", 32'({slm, epd, opd, lane_pd}), 32'({lw, ep, odd, {4{ep}}}));
			rd_chk(`REG_STATUS, 32'({1'b1, odd, ep, op, ep, lw}));
			rd_chk(4'hF, 32'h0);
			wr_reg(`REG_OVERRIDE, 32'h5);
			check("ovr0", 32'({epd, opd}), 32'({1'b0, !lw}));
			rd_chk(`REG_OVERRIDE, 32'h5);
			wr_reg(`REG_OVERRIDE, 32'hF);
			check("ovr1", 32'({epd, opd, lane_pd}), 32'h3F);
			$display("case %0d done", i);
		end
		wr_reg(`REG_TEST, 32'h3);
		check("drive", 32'({soe_n, so, slm}), 32'h0F);
		rd_chk(`REG_TEST, 32'h3);
		wr_reg(`REG_TEST, 32'h0);
		check("undrive", 32'(soe_n), 32'h7);
		$display("test mode done");
		close_out();
	end
endmodule
